/* logic/charger_defines.vh */
// Shared constants for the charger pin control and status logic.
`ifndef CHARGER_DEFINES_VH
`define CHARGER_DEFINES_VH

// ----------------------------------------------------------------------
// Timebase
// ----------------------------------------------------------------------
`define CLK_KHZ 50000
`define CLK_MHZ 50
`define TIMER_W 29

// ----------------------------------------------------------------------
// Documented times, each in its own unit
// ----------------------------------------------------------------------
`define ALERT_PULSE_US 256
`define SHIP_EXIT_PULSE_MS 1000
`define LONG_RESET_PULSE_MS 10000
`define SWITCH_OFF_RESET_MS 320
`define BLINK_HALF_PERIOD_MS 500
`define DEBOUNCE_US 10

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define ADDR_W 4
`define DATA_W 8
`define REG_CTRL 4'h0
`define REG_ILIM 4'h1
`define REG_DPDM 4'h2
`define REG_STATUS 4'h3

// ----------------------------------------------------------------------
// Control register fields and reset values
// ----------------------------------------------------------------------
`define CTRL_CHARGE_CFG 0
`define CTRL_DIRECT_EN 1
`define CTRL_STAT_FN_LO 2
`define CTRL_STAT_FN_HI 3
`define CTRL_SHIP_ENTER 4
`define CHARGE_CFG_RST 1'b1
`define STAT_FN_RST 2'h0
`define STAT_FN_DISABLE 2'h3

// ----------------------------------------------------------------------
// Input current limit codes, 100 mA per step from 100 mA
// ----------------------------------------------------------------------
`define ILIM_W 5
`define ILIM_CODE_500MA 5'h04
`define ILIM_CODE_2400MA 5'h17

// ----------------------------------------------------------------------
// Data line level fields
// ----------------------------------------------------------------------
`define DPDM_DP_LO 0
`define DPDM_DP_HI 1
`define DPDM_DM_LO 2
`define DPDM_DM_HI 3
`define LEVEL_RST 2'h0

// ----------------------------------------------------------------------
// Status register layout
// ----------------------------------------------------------------------
`define STATUS_EVENT_W 5
`define ST_POWER_GOOD 0
`define ST_CHARGING 1
`define ST_DONE 2
`define ST_FAULT 3
`define ST_TEMP_OK 4
`define ST_SHIP_MODE 5
`define ST_ILIM_HOST 6
`define ST_SWITCH_RST 7

`endif

/* logic/charger_pin_control_status.v */
// Pin-level control and status logic of a single-cell charger.
`timescale 1ns/1ps
`default_nettype none
`include "charger_defines.vh"

module charger_pin_control_status #(
  parameter [31:0] ALERT_CYCLES = `ALERT_PULSE_US * `CLK_MHZ,
  parameter [31:0] SHIP_EXIT_CYCLES = `SHIP_EXIT_PULSE_MS * `CLK_KHZ,
  parameter [31:0] LONG_RESET_CYCLES = `LONG_RESET_PULSE_MS * `CLK_KHZ,
  parameter [31:0] SWITCH_OFF_CYCLES = `SWITCH_OFF_RESET_MS * `CLK_KHZ,
  parameter [31:0] BLINK_HALF_CYCLES = `BLINK_HALF_PERIOD_MS * `CLK_KHZ
) (
  input wire ref_clk_in,
  input wire reset_in,
  input wire [`ADDR_W-1:0] reg_addr_in,
  input wire [`DATA_W-1:0] reg_wdata_in,
  input wire reg_write_in,
  input wire reg_read_in,
  output reg [`DATA_W-1:0] reg_rdata_out,
  input wire source_select_in,
  input wire charge_enable_n_in,
  input wire switch_control_n_in,
  input wire vbus_present_in,
  input wire battery_present_in,
  input wire vbus_above_uvlo_in,
  input wire vbus_below_ov_in,
  input wire vbus_above_sleep_in,
  input wire weak_source_ok_in,
  input wire temp_in_window_in,
  input wire charge_done_in,
  input wire charge_fault_in,
  output reg [`ILIM_W-1:0] input_current_limit_out,
  output reg charge_allowed_out,
  output reg direct_charge_enable_out,
  output reg battery_system_switch_out,
  output reg switch_control_pullup_out,
  output reg [1:0] dplus_level_sel_out,
  output reg [1:0] dminus_level_sel_out,
  output wire charge_status_out,
  output reg charge_status_oe_out,
  output wire host_alert_n_out,
  output wire host_alert_n_oe_out,
  output wire power_good_n_out,
  output reg power_good_n_oe_out
);

  // --------------------------------------------------------------------
  // Derived counts
  // --------------------------------------------------------------------
  localparam DEBOUNCE_CYCLES = `DEBOUNCE_US * `CLK_MHZ;
  localparam DEB_W = 10;
  localparam [DEB_W-1:0] DEB_ONE = {{(DEB_W-1){1'b0}}, 1'b1};
  localparam [`TIMER_W-1:0] ONE = {{(`TIMER_W-1){1'b0}}, 1'b1};

  // --------------------------------------------------------------------
  // Software-visible state
  // --------------------------------------------------------------------
  reg charge_config_bit;
  reg [1:0] status_pin_function_sel;
  reg ship_mode;
  reg ilim_host;
  reg [`ILIM_W-1:0] input_current_limit_field;

  // --------------------------------------------------------------------
  // Charge qualification
  // --------------------------------------------------------------------
  wire power_good;
  wire charge_requested;
  wire charge_ok;
  wire suspended;
  wire charging;

  assign power_good = vbus_above_uvlo_in && vbus_below_ov_in &&
    vbus_above_sleep_in && weak_source_ok_in;
  assign charge_requested = charge_config_bit &&
    !charge_enable_n_in;
  assign charge_ok = charge_requested && power_good &&
    temp_in_window_in;
  // A charge wanted but stopped by a fault or the thermal window blinks.
  assign suspended = charge_requested && power_good &&
    (charge_fault_in || !temp_in_window_in);
  assign charging = charge_ok && !charge_fault_in && !charge_done_in;

  // --------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------
  wire ship_exit;

  always @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      charge_config_bit <= `CHARGE_CFG_RST;
      direct_charge_enable_out <= 1'b0;
      status_pin_function_sel <= `STAT_FN_RST;
      ilim_host <= 1'b0;
      input_current_limit_field <= `ILIM_CODE_500MA;
      dplus_level_sel_out <= `LEVEL_RST;
      dminus_level_sel_out <= `LEVEL_RST;
    end
    else
    begin
      if (reg_write_in && reg_addr_in == `REG_CTRL)
      begin
        charge_config_bit <= reg_wdata_in[`CTRL_CHARGE_CFG];
        direct_charge_enable_out <= reg_wdata_in[`CTRL_DIRECT_EN];
        status_pin_function_sel <=
          reg_wdata_in[`CTRL_STAT_FN_HI:`CTRL_STAT_FN_LO];
      end
      else if (reg_write_in && reg_addr_in == `REG_ILIM)
      begin
        ilim_host <= 1'b1;
        input_current_limit_field <= reg_wdata_in[`ILIM_W-1:0];
      end
      else if (reg_write_in && reg_addr_in == `REG_DPDM)
      begin
        dplus_level_sel_out <=
          reg_wdata_in[`DPDM_DP_HI:`DPDM_DP_LO];
        dminus_level_sel_out <=
          reg_wdata_in[`DPDM_DM_HI:`DPDM_DM_LO];
      end
      // Until the host writes a limit, the source select pin decides.
      if (!ilim_host && !(reg_write_in && reg_addr_in == `REG_ILIM))
        input_current_limit_field <= source_select_in ?
          `ILIM_CODE_500MA : `ILIM_CODE_2400MA;
    end
  end

  // Entering ship mode is a host write; leaving it is a press held for SHIP_EXIT_CYCLES.
  always @(posedge ref_clk_in)
  begin
    if (reset_in)
      ship_mode <= 1'b0;
    else if (reg_write_in && reg_addr_in == `REG_CTRL &&
      reg_wdata_in[`CTRL_SHIP_ENTER])
      ship_mode <= 1'b1;
    else if (ship_exit)
      ship_mode <= 1'b0;
  end

  // --------------------------------------------------------------------
  // Switch control input debounce and low-time measurement
  // --------------------------------------------------------------------
  reg switch_low;
  reg [DEB_W-1:0] deb_count;
  reg [`TIMER_W-1:0] low_count;
  wire long_press;

  always @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      switch_low <= 1'b0;
      deb_count <= {DEB_W{1'b0}};
    end
    else if (switch_low == !switch_control_n_in)
      deb_count <= {DEB_W{1'b0}};
    else if (deb_count == DEBOUNCE_CYCLES[DEB_W-1:0] - DEB_ONE)
    begin
      switch_low <= !switch_control_n_in;
      deb_count <= {DEB_W{1'b0}};
    end
    else
      deb_count <= deb_count + DEB_ONE;
  end

  // The count saturates so a held button fires each action only once.
  always @(posedge ref_clk_in)
  begin
    if (reset_in || !switch_low)
      low_count <= {`TIMER_W{1'b0}};
    else if (low_count != LONG_RESET_CYCLES[`TIMER_W-1:0])
      low_count <= low_count + ONE;
  end

  assign ship_exit = switch_low && ship_mode &&
    low_count == SHIP_EXIT_CYCLES[`TIMER_W-1:0] - ONE;
  assign long_press = switch_low && !vbus_present_in &&
    low_count == LONG_RESET_CYCLES[`TIMER_W-1:0] - ONE;

  // --------------------------------------------------------------------
  // Timers
  // --------------------------------------------------------------------
  wire switch_off_busy;
  wire alert_busy;
  wire alert_start;
  wire blink_done;
  wire blink_busy;
  reg blink_phase;

  interval_timer #(.WIDTH(`TIMER_W)) switch_off_timer (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .start_in(long_press),
    .load_in(SWITCH_OFF_CYCLES[`TIMER_W-1:0]),
    .busy_out(switch_off_busy),
    .done_out()
  );

  interval_timer #(.WIDTH(`TIMER_W)) alert_timer (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .start_in(alert_start),
    .load_in(ALERT_CYCLES[`TIMER_W-1:0]),
    .busy_out(alert_busy),
    .done_out()
  );

  interval_timer #(.WIDTH(`TIMER_W)) blink_timer (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .start_in(suspended && (!blink_busy || blink_done)),
    .load_in(BLINK_HALF_CYCLES[`TIMER_W-1:0]),
    .busy_out(blink_busy),
    .done_out(blink_done)
  );

  // Each half period flips the phase; out of suspend it starts high.
  always @(posedge ref_clk_in)
  begin
    if (reset_in || !suspended)
      blink_phase <= 1'b1;
    else if (blink_done)
      blink_phase <= !blink_phase;
  end

  // --------------------------------------------------------------------
  // Status change detection for the alert line
  // --------------------------------------------------------------------
  wire [`STATUS_EVENT_W-1:0] status_now;
  reg [`STATUS_EVENT_W-1:0] status_prev;

  assign status_now = {temp_in_window_in, charge_fault_in,
    charge_done_in, charging, power_good};

  // Tracked through reset as well, so release raises no false alert.
  always @(posedge ref_clk_in)
  begin
    status_prev <= status_now;
  end

  // Compared against live inputs so a fault raises the alert at once.
  assign alert_start = (status_now != status_prev);

  // --------------------------------------------------------------------
  // Pin drive
  // --------------------------------------------------------------------
  assign charge_status_out = 1'b0;
  assign host_alert_n_out = 1'b0;
  assign power_good_n_out = 1'b0;
  assign host_alert_n_oe_out = alert_busy;

  always @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      charge_status_oe_out <= 1'b0;
      power_good_n_oe_out <= 1'b0;
      charge_allowed_out <= 1'b0;
      battery_system_switch_out <= 1'b1;
      switch_control_pullup_out <= 1'b0;
      input_current_limit_out <= `ILIM_CODE_500MA;
    end
    else
    begin
      if (status_pin_function_sel == `STAT_FN_DISABLE)
        charge_status_oe_out <= 1'b0;
      else if (suspended)
        charge_status_oe_out <= blink_phase;
      else
        charge_status_oe_out <= charging;
      power_good_n_oe_out <= power_good;
      charge_allowed_out <= charge_ok;
      battery_system_switch_out <= !ship_mode &&
        !switch_off_busy;
      switch_control_pullup_out <= vbus_present_in ||
        battery_present_in;
      input_current_limit_out <= input_current_limit_field;
    end
  end

  // --------------------------------------------------------------------
  // Register reads
  // --------------------------------------------------------------------
  reg [`DATA_W-1:0] next_rdata;

  always @*
  begin
    next_rdata = {`DATA_W{1'b0}};
    if (reg_addr_in == `REG_CTRL)
    begin
      next_rdata[`CTRL_CHARGE_CFG] = charge_config_bit;
      next_rdata[`CTRL_DIRECT_EN] = direct_charge_enable_out;
      next_rdata[`CTRL_STAT_FN_HI:`CTRL_STAT_FN_LO] =
        status_pin_function_sel;
      next_rdata[`CTRL_SHIP_ENTER] = ship_mode;
    end
    else if (reg_addr_in == `REG_ILIM)
      next_rdata[`ILIM_W-1:0] = input_current_limit_field;
    else if (reg_addr_in == `REG_DPDM)
    begin
      next_rdata[`DPDM_DP_HI:`DPDM_DP_LO] = dplus_level_sel_out;
      next_rdata[`DPDM_DM_HI:`DPDM_DM_LO] = dminus_level_sel_out;
    end
    else if (reg_addr_in == `REG_STATUS)
    begin
      next_rdata[`STATUS_EVENT_W-1:0] = status_now;
      next_rdata[`ST_SHIP_MODE] = ship_mode;
      next_rdata[`ST_ILIM_HOST] = ilim_host;
      next_rdata[`ST_SWITCH_RST] = switch_off_busy;
    end
  end

  // Read data stand only in the cycle after the strobe; zero otherwise.
  always @(posedge ref_clk_in)
  begin
    if (reset_in || !reg_read_in)
      reg_rdata_out <= {`DATA_W{1'b0}};
    else
      reg_rdata_out <= next_rdata;
  end

endmodule

`default_nettype wire

/* logic/interval_timer.v */
// One-shot down-counting interval timer used for pulses and delays.
`timescale 1ns/1ps
`default_nettype none

module interval_timer #(
  parameter WIDTH = 29
) (
  input wire ref_clk_in,
  input wire reset_in,
  input wire start_in,
  input wire [WIDTH-1:0] load_in,
  output reg busy_out,
  output wire done_out
);

  reg [WIDTH-1:0] count;

  // A start while busy reloads, so a retrigger stretches the interval.
  always @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      busy_out <= 1'b0;
      count <= {WIDTH{1'b0}};
    end
    else if (start_in)
    begin
      busy_out <= 1'b1;
      count <= load_in;
    end
    else if (busy_out)
    begin
      count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
      if (count == {{(WIDTH-1){1'b0}}, 1'b1})
        busy_out <= 1'b0;
    end
  end

  // Done looks only at the registered count and busy flag, so a start fed
  // back from done forms no combinational loop.
  assign done_out = busy_out &&
    (count == {{(WIDTH-1){1'b0}}, 1'b1});

endmodule

`default_nettype wire

/* sim/charger_pin_control_status_asserts.sv */
// Concurrent checks on the charger pin control and status block.
`timescale 1ns/1ps
`default_nettype none
module charger_checker (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic source_select_in,
  input wire logic charge_enable_n_in,
  input wire logic vbus_above_uvlo_in,
  input wire logic vbus_below_ov_in,
  input wire logic vbus_above_sleep_in,
  input wire logic weak_source_ok_in,
  input wire logic temp_in_window_in,
  input wire logic charge_done_in,
  input wire logic charge_fault_in,
  input wire logic [4:0] input_current_limit_out,
  input wire logic charge_allowed_out,
  input wire logic direct_charge_enable_out,
  input wire logic battery_system_switch_out,
  input wire logic [1:0] dplus_level_sel_out,
  input wire logic [1:0] dminus_level_sel_out,
  input wire logic charge_status_oe_out,
  input wire logic host_alert_n_oe_out,
  input wire logic power_good_n_oe_out
);
  // ----------
  // Shadow of the written fields, so outputs can be tied to writes.
  // ----------
  logic ovr, cfg, direct_en;
  logic [1:0] fn;
  logic [4:0] ilim;
  logic [3:0] lvl;
  wire good = vbus_above_uvlo_in && vbus_below_ov_in &&
    vbus_above_sleep_in && weak_source_ok_in;
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      ovr <= 1'b0;
      cfg <= 1'b1;
      direct_en <= 1'b0;
      fn <= 2'h0;
      ilim <= 5'h00;
      lvl <= 4'h0;
    end
    else if (reg_write_in)
    begin
      if (reg_addr_in == 4'h0)
      begin
        cfg <= reg_wdata_in[0];
        direct_en <= reg_wdata_in[1];
        fn <= reg_wdata_in[3:2];
      end
      if (reg_addr_in == 4'h1)
      begin
        ovr <= 1'b1;
        ilim <= reg_wdata_in[4:0];
      end
      if (reg_addr_in == 4'h2)
        lvl <= reg_wdata_in[3:0];
    end
  end
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (reset_in);
  limit_default_a: assert property (
    !$past(ovr) && !$past(reset_in) && !$past(reset_in, 2) |->
    input_current_limit_out ==
    ($past(source_select_in, 2) ? 5'h04 : 5'h17)) else $error("bad limit");
  host_limit_a: assert property (
    $past(ovr) |-> input_current_limit_out == $past(ilim))
    else $error("host limit lost");
  status_done_a: assert property (
    charge_done_in && !charge_fault_in && temp_in_window_in
    |=> !charge_status_oe_out) else $error("status low when done");
  status_off_a: assert property (
    fn == 2'h3 |=> !charge_status_oe_out) else $error("status not off");
  alert_hold_a: assert property (
    $rose(host_alert_n_oe_out) |-> host_alert_n_oe_out [*8])
    else $error("alert too short");
  alert_fault_a: assert property (
    $changed(charge_fault_in) |-> ##[1:2] host_alert_n_oe_out)
    else $error("no alert on fault");
  charge_gate_a: assert property (
    charge_allowed_out |-> !$past(charge_enable_n_in) && $past(cfg) &&
    $past(temp_in_window_in)) else $error("charge not gated");
  direct_charge_a: assert property (
    !$past(reset_in) |-> direct_charge_enable_out == direct_en)
    else $error("direct charge wrong");
  ship_off_a: assert property (
    reg_write_in && reg_addr_in == 4'h0 && reg_wdata_in[4]
    |-> ##2 !battery_system_switch_out) else $error("switch on in ship");
  power_good_a: assert property (
    !$past(reset_in) |-> power_good_n_oe_out == $past(good))
    else $error("power good wrong");
  line_level_a: assert property (
    !$past(reset_in) |-> {dminus_level_sel_out, dplus_level_sel_out}
    == lvl) else $error("line level wrong");
endmodule
bind charger_pin_control_status charger_checker i_charger_checker (
  .ref_clk_in, .reset_in, .reg_addr_in, .reg_wdata_in, .reg_write_in,
  .source_select_in, .charge_enable_n_in, .vbus_above_uvlo_in,
  .vbus_below_ov_in, .vbus_above_sleep_in, .weak_source_ok_in,
  .temp_in_window_in, .charge_done_in, .charge_fault_in,
  .input_current_limit_out, .charge_allowed_out, .direct_charge_enable_out,
  .battery_system_switch_out, .dplus_level_sel_out, .dminus_level_sel_out,
  .charge_status_oe_out, .host_alert_n_oe_out, .power_good_n_oe_out);
`default_nettype wire

/* sim/charger_pin_control_status_bench.sv */
// Self-checking bench for the charger pin control and status block.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin \
  n_compared++; \
  if ((got) !== (exp)) \
  begin \
    failures++; \
    $display("MISMATCH at %0t got %h expected %h", $time, got, exp); \
  end \
end
module charger_pin_control_status_bench;
  logic ref_clk_in, reset_in, reg_write_in, reg_read_in, source_select_in;
  logic charge_enable_n_in, switch_control_n_in, vbus_present_in;
  logic battery_present_in, vbus_above_uvlo_in, vbus_below_ov_in;
  logic vbus_above_sleep_in, weak_source_ok_in, temp_in_window_in;
  logic charge_done_in, charge_fault_in, charge_allowed_out;
  logic direct_charge_enable_out, battery_system_switch_out;
  logic switch_control_pullup_out, charge_status_oe_out;
  logic host_alert_n_oe_out, power_good_n_oe_out;
  logic [3:0] reg_addr_in;
  logic [7:0] reg_wdata_in, reg_rdata_out, d;
  logic [4:0] input_current_limit_out;
  logic [1:0] dplus_level_sel_out, dminus_level_sel_out;
  wire [2:0] od;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  int n;
  charger_pin_control_status #(.ALERT_CYCLES(32'd20),
    .SHIP_EXIT_CYCLES(32'd100), .LONG_RESET_CYCLES(32'd300),
    .SWITCH_OFF_CYCLES(32'd50), .BLINK_HALF_CYCLES(32'd16))
  i_charger_pin_control_status (.ref_clk_in, .reset_in, .reg_addr_in,
    .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out,
    .source_select_in, .charge_enable_n_in, .switch_control_n_in,
    .vbus_present_in, .battery_present_in, .vbus_above_uvlo_in,
    .vbus_below_ov_in, .vbus_above_sleep_in, .weak_source_ok_in,
    .temp_in_window_in, .charge_done_in, .charge_fault_in,
    .input_current_limit_out, .charge_allowed_out,
    .direct_charge_enable_out, .battery_system_switch_out,
    .switch_control_pullup_out, .dplus_level_sel_out,
    .dminus_level_sel_out, .charge_status_out(od[0]), .charge_status_oe_out,
    .host_alert_n_out(od[1]), .host_alert_n_oe_out, .power_good_n_out(od[2]),
    .power_good_n_oe_out);
  host_model i_host_model (.ref_clk_in, .reg_rdata_in(reg_rdata_out),
    .alert_oe_in(host_alert_n_oe_out), .reg_addr_out(reg_addr_in),
    .reg_wdata_out(reg_wdata_in), .reg_write_out(reg_write_in),
    .reg_read_out(reg_read_in));
  initial
  begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      results();
    end
  end
  task automatic results();
  begin
    $display("Compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  task automatic wt(input int k);
    repeat (k) @(negedge ref_clk_in);
  endtask
  // Holds the button low for k cycles, then leaves time to debounce high.
  task automatic press(input int k);
  begin
    @(posedge ref_clk_in) switch_control_n_in <= 1'b0;
    repeat (k) @(posedge ref_clk_in);
    switch_control_n_in <= 1'b1;
    wt(600);
  end
  endtask
  // ----------
  // Scenarios
  // ----------
  task automatic t_limit();
  begin
    wt(3);
    `CHECK(input_current_limit_out, 5'h04)
    @(posedge ref_clk_in) source_select_in <= 1'b0;
    wt(3);
    `CHECK(input_current_limit_out, 5'h17)
    i_host_model.read_reg(4'h9, d);
    `CHECK(d, 8'h00)
    i_host_model.write_reg(4'h1, 8'h0a);
    @(posedge ref_clk_in) source_select_in <= 1'b1;
    wt(4);
    `CHECK(input_current_limit_out, 5'h0a)
    i_host_model.read_reg(4'h3, d);
    `CHECK(d, 8'h51)
    i_host_model.write_reg(4'h2, 8'h0e);
    i_host_model.read_reg(4'h0, d);
    `CHECK(d, 8'h01)
    `CHECK({dminus_level_sel_out, dplus_level_sel_out}, 4'he)
    `CHECK(od, 3'h0)
  end
  endtask
  task automatic t_charge();
  begin
    @(posedge ref_clk_in) charge_enable_n_in <= 1'b0;
    wt(3);
    `CHECK({charge_allowed_out, charge_status_oe_out}, 2'b11)
    i_host_model.write_reg(4'h0, 8'h02);
    wt(3);
    `CHECK(charge_allowed_out, 1'b0)
    `CHECK(direct_charge_enable_out, 1'b1)
    i_host_model.write_reg(4'h0, 8'h01);
    @(posedge ref_clk_in) vbus_above_uvlo_in <= 1'b0;
    wt(3);
    `CHECK({power_good_n_oe_out, charge_allowed_out}, 2'b00)
    @(posedge ref_clk_in) vbus_above_uvlo_in <= 1'b1;
    weak_source_ok_in <= 1'b0;
    wt(3);
    `CHECK(power_good_n_oe_out, 1'b0)
    @(posedge ref_clk_in) weak_source_ok_in <= 1'b1;
    charge_done_in <= 1'b1;
    wt(3);
    `CHECK(charge_status_oe_out, 1'b0)
    @(posedge ref_clk_in) charge_done_in <= 1'b0;
    wt(30);
  end
  endtask
  task automatic t_blink();
  begin
    n = i_host_model.alerts;
    @(posedge ref_clk_in) charge_fault_in <= 1'b1;
    wt(4);
    `CHECK(i_host_model.alerts, n + 1)
    n = 0;
    repeat (64)
    begin
      wt(1);
      n += charge_status_oe_out;
    end
    `CHECK(n, 32)
    @(posedge ref_clk_in) charge_fault_in <= 1'b0;
    temp_in_window_in <= 1'b0;
    wt(3);
    `CHECK(charge_allowed_out, 1'b0)
    i_host_model.write_reg(4'h0, 8'h0d);
    wt(2);
    n = 0;
    repeat (40)
    begin
      wt(1);
      n += (charge_status_oe_out !== 1'b0);
    end
    `CHECK(n, 0)
    i_host_model.write_reg(4'h0, 8'h01);
    @(posedge ref_clk_in) temp_in_window_in <= 1'b1;
    charge_enable_n_in <= 1'b1;
    wt(30);
    @(posedge ref_clk_in) temp_in_window_in <= 1'b0;
    n = 0;
    repeat (40)
    begin
      wt(1);
      n += host_alert_n_oe_out;
    end
    `CHECK(n, 20)
    @(posedge ref_clk_in) temp_in_window_in <= 1'b1;
    wt(30);
  end
  endtask
  task automatic t_ship();
  begin
    i_host_model.write_reg(4'h0, 8'h11);
    i_host_model.read_reg(4'h0, d);
    `CHECK({d[4], battery_system_switch_out}, 2'b10)
    press(400);
    `CHECK(battery_system_switch_out, 1'b0)
    press(700);
    `CHECK(battery_system_switch_out, 1'b1)
  end
  endtask
  task automatic t_long();
  begin
    @(posedge ref_clk_in) vbus_present_in <= 1'b0;
    switch_control_n_in <= 1'b0;
    n = 0;
    while (battery_system_switch_out === 1'b1 && n < 1000)
    begin
      wt(1);
      n++;
    end
    `CHECK(n > 795 && n < 810, 1'b1)
    n = 0;
    while (battery_system_switch_out === 1'b0 && n < 200)
    begin
      wt(1);
      n++;
    end
    `CHECK(n > 47 && n < 54, 1'b1)
    wt(100);
    `CHECK(battery_system_switch_out, 1'b1)
    `CHECK(switch_control_pullup_out, 1'b1)
    @(posedge ref_clk_in) switch_control_n_in <= 1'b1;
    battery_present_in <= 1'b0;
    wt(3);
    `CHECK(switch_control_pullup_out, 1'b0)
  end
  endtask
  initial
  begin
    reset_in = 1'b1;
    source_select_in = 1'b1;
    charge_enable_n_in = 1'b1;
    switch_control_n_in = 1'b1;
    vbus_present_in = 1'b1;
    battery_present_in = 1'b1;
    vbus_above_uvlo_in = 1'b1;
    vbus_below_ov_in = 1'b1;
    vbus_above_sleep_in = 1'b1;
    weak_source_ok_in = 1'b1;
    temp_in_window_in = 1'b1;
    charge_done_in = 1'b0;
    charge_fault_in = 1'b0;
    repeat (10) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    t_limit();
    t_charge();
    t_blink();
    t_ship();
    t_long();
    results();
  end
endmodule
`default_nettype wire

/* sim/host_model.sv */
// Host side model: register bus master and alert pulse counter.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic ref_clk_in,
  input wire logic [7:0] reg_rdata_in,
  input wire logic alert_oe_in,
  output logic [3:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  output logic reg_write_out,
  output logic reg_read_out
);
  int alerts = 0;
  initial
  begin
    reg_addr_out = 4'h0;
    reg_wdata_out = 8'h00;
    reg_write_out = 1'b0;
    reg_read_out = 1'b0;
  end
  // The alert pin drive is registered, so its edge is glitch free.
  always @(posedge alert_oe_in)
    alerts++;
  task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
  begin
    @(posedge ref_clk_in);
    reg_addr_out <= a;
    reg_wdata_out <= d;
    reg_write_out <= 1'b1;
    @(posedge ref_clk_in);
    reg_write_out <= 1'b0;
  end
  endtask
  task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
  begin
    @(posedge ref_clk_in);
    reg_addr_out <= a;
    reg_read_out <= 1'b1;
    @(posedge ref_clk_in);
    reg_read_out <= 1'b0;
    @(negedge ref_clk_in);
    d = reg_rdata_in;
  end
  endtask
endmodule
`default_nettype wire
